// ===== rtl/gmf_pkg.sv
package gmf_pkg;
    typedef enum logic [3:0]
    {
        GMF_INIT = 4'b0001,
        GMF_SEND = 4'b0010,
        GMF_NORMAL = 4'b0100,
        GMF_SERVICE = 4'b1000
    } gmf_mode_type;
    typedef enum logic [1:0]
    {
        GMF_DG_MEAS = 2'h0,
        GMF_DG_PART = 2'h1,
        GMF_DG_SERIAL = 2'h2,
        GMF_DG_CONFIG = 2'h3
    } gmf_dg_type;
    localparam logic [11:0] GMF_CTRL_OFS = 12'h000;
    localparam logic [11:0] GMF_CMD_OFS = 12'h004;
    localparam logic [11:0] GMF_STAT_OFS = 12'h008;
    localparam logic [11:0] GMF_LAST_OFS = 12'h00c;
    localparam logic [31:0] GMF_CTRL_RST = 32'h0000_0400;
    localparam int GMF_UNIT_LSB = 0;
    localparam int GMF_TRIG_BIT = 2;
    localparam int GMF_LPF_LSB = 4;
    localparam int GMF_DIV_LSB = 8;
    localparam logic [1:0] GMF_UNIT_RATE = 2'h0;
    localparam logic [1:0] GMF_UNIT_INCR = 2'h1;
    localparam logic [1:0] GMF_UNIT_AVG = 2'h2;
    localparam int GMF_CMD_RESET = 0;
    localparam int GMF_CMD_PART = 1;
    localparam int GMF_CMD_SERIAL = 2;
    localparam int GMF_CMD_CONFIG = 3;
    localparam int GMF_CMD_SVC = 4;
    localparam int GMF_CMD_EXIT_NORM = 5;
    localparam int GMF_CMD_EXIT_INIT = 6;
    localparam int GMF_ST_SYS = 7;
    localparam int GMF_ST_START = 6;
    localparam int GMF_CLK_HZ = 100_000_000;
    localparam int GMF_INT_SPS = 1000;
    localparam int GMF_SAMPLE_CYCLES = GMF_CLK_HZ / GMF_INT_SPS;
    localparam int GMF_US_CYCLES = GMF_CLK_HZ / 1_000_000;
    localparam int GMF_SETTLE_MS = 10;
    localparam int GMF_SETTLE_CYCLES = GMF_SETTLE_MS * (GMF_CLK_HZ / 1000);
    localparam int GMF_STARTUP_MS = 100;
    localparam int GMF_STARTUP_CYCLES = GMF_STARTUP_MS * (GMF_CLK_HZ / 1000);
    // rate lsb 2^-14 deg/s over 1 ms gives angle lsb 2^-21 deg: x 2^7 / 1000
    localparam int GMF_INCR_MUL = 128;
    localparam int GMF_INCR_DIV = GMF_INT_SPS;
endpackage

// ===== rtl/gmf_formatter.sv
// Function
// R1 - active-low reset pin forces Init Mode
// R2 - enter Init on power, pin, commands
// R3 - Init settles, resets channels, sends specials
// R4 - all three specials sent, go Normal
// R5 - host may request specials in Normal
// R6 - sample at 1000/s; send rate or trigger
// R7 - keep sending even with status errors
// R8 - start-up period flagged by status bit 6
// R9 - service-to-normal skips start-up period
// R10 - triggered mode sends only after falling edge
// R11 - one datagram per edge, latest data
// R12 - specials unprompted; service ignores trigger
// R13 - latency from last sample to trigger
// R14 - rate unit sends latest sample only
// R15 - rate is 24-bit, lsb 2^-14 deg/s
// R16 - incremental angle restarts after each send
// R17 - angle is 24-bit, lsb 2^-21 deg
// R18 - average is mean since last send
// R19 - low-pass filter before averaging
// R20 - status byte bit layout 7..0
// R21 - status never latched between datagrams
// R22 - specials in order part, serial, config
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module gmf_formatter
#(
    parameter int SAMPLE_CYCLES = gmf_pkg::GMF_SAMPLE_CYCLES,
    parameter int SETTLE_CYCLES = gmf_pkg::GMF_SETTLE_CYCLES,
    parameter int STARTUP_CYCLES = gmf_pkg::GMF_STARTUP_CYCLES,
    // identity values are arbitrary
    parameter logic [23:0] PART_ID = 24'h00a5a5,
    parameter logic [23:0] SERIAL_ID = 24'h000001
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic module_reset_low,
    input wire logic sample_trigger_in,
    input wire logic signed [23:0] rate_x,
    input wire logic signed [23:0] rate_y,
    input wire logic signed [23:0] rate_z,
    input wire logic [7:0] diag_status,
    input wire logic tx_ready,
    output logic dg_valid,
    output gmf_pkg::gmf_dg_type dg_kind,
    output logic [23:0] dg_x,
    output logic [23:0] dg_y,
    output logic [23:0] dg_z,
    output logic [7:0] dg_status,
    output logic [7:0] dg_count,
    output logic [15:0] dg_latency
);
    import gmf_pkg::*;

    function automatic logic signed [23:0] lpf(
        input logic signed [23:0] old,
        input logic signed [23:0] smp,
        input logic [3:0] sh
    );
        logic signed [24:0] d;
        d = 25'(smp) - 25'(old);
        d = d >>> sh;
        return 24'(25'(old) + d);
    endfunction

    function automatic logic [23:0] fmt(
        input logic signed [47:0] sum,
        input logic [15:0] cnt,
        input logic signed [23:0] last,
        input logic [1:0] unit
    );
        logic signed [47:0] v;
        v = 48'(last);
        if (unit == GMF_UNIT_INCR)
        begin
            v = (sum * 48'sd128) / 48'sd1000;
        end
        else if (unit == GMF_UNIT_AVG && cnt != 16'h0000)
        begin
            v = sum / $signed({32'h0, cnt});
        end
        if (v > 48'sh7fffff)
        begin
            v = 48'sh7fffff;
        end
        else if (v < -48'sh800000)
        begin
            v = -48'sh800000;
        end
        return v[23:0];
    endfunction

    gmf_mode_type mode_r;
    logic rst_s1_r, rst_s2_r;
    logic trg_s1_r, trg_s2_r, trg_s3_r;
    logic [31:0] ctrl_r;
    logic [31:0] timer_r;
    logic [31:0] smp_cnt_r;
    logic tick_r;
    logic [6:0] us_cnt_r;
    logic [15:0] lat_r;
    logic [7:0] div_cnt_r;
    logic [7:0] free_cnt_r;
    logic startup_r;
    logic [3:0] pend_r;
    logic [3:0] pend_nxt;
    logic signed [23:0] filt_r [3];
    logic signed [23:0] filt_nxt [3];
    logic signed [47:0] sum_r [3];
    logic [15:0] acc_cnt_r;
    logic [3:0] emit;
    logic [6:0] cmd;
    logic ext_rst, trig_fall, timer_done, to_init, send_done;
    logic wr_en, rd_hit;
    logic [31:0] rd_val;
    logic [1:0] unit;
    logic trig_mode;
    logic [7:0] div_eff;
    logic meas_set;
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r;
    logic dg_valid_r;
    gmf_dg_type dg_kind_r;
    logic [23:0] dg_x_r, dg_y_r, dg_z_r;
    logic [7:0] dg_status_r, dg_count_r;
    logic [15:0] dg_latency_r;

    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign dg_valid = dg_valid_r;
    assign dg_kind = dg_kind_r;
    assign dg_x = dg_x_r;
    assign dg_y = dg_y_r;
    assign dg_z = dg_z_r;
    assign dg_status = dg_status_r;
    assign dg_count = dg_count_r;
    assign dg_latency = dg_latency_r;

    assign unit = ctrl_r[GMF_UNIT_LSB +: 2];
    assign trig_mode = ctrl_r[GMF_TRIG_BIT];
    assign div_eff = (ctrl_r[GMF_DIV_LSB +: 8] == 8'h00) ? 8'h01 : ctrl_r[GMF_DIV_LSB +: 8];

    // pins are asynchronous; reset pin idles high like its pull-up
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= 1'b1;
            trg_s1_r <= 1'b0;
            trg_s2_r <= 1'b0;
            trg_s3_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= module_reset_low;
            rst_s2_r <= rst_s1_r;
            trg_s1_r <= sample_trigger_in;
            trg_s2_r <= trg_s1_r;
            trg_s3_r <= trg_s2_r;
        end
    end
    assign ext_rst = !rst_s2_r; // R1
    assign trig_fall = trg_s3_r && !trg_s2_r; // R10

    // apb: zero-wait, pready raised in the access cycle
    assign wr_en = psel && penable && pready_r && pwrite;
    assign cmd = wr_en && paddr == GMF_CMD_OFS ? pwdata[6:0] : 7'h00;
    always_comb
    begin
        rd_hit = 1'b1;
        rd_val = 32'h0;
        case (paddr)
            GMF_CTRL_OFS: rd_val = ctrl_r;
            GMF_CMD_OFS: rd_val = 32'h0;
            GMF_STAT_OFS: rd_val = {23'h0, startup_r, pend_r, mode_r};
            GMF_LAST_OFS: rd_val = {16'h0, free_cnt_r, dg_status_r};
            default: rd_hit = 1'b0;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= psel && !penable && !pready_r;
            if (psel && !penable)
            begin
                prdata_r <= pwrite ? 32'h0 : rd_val;
                pslverr_r <= !rd_hit;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= GMF_CTRL_RST;
        end
        else if (wr_en && paddr == GMF_CTRL_OFS)
        begin
            ctrl_r <= {16'h0, pwdata[15:0]};
        end
    end

    // mode sequencing
    assign timer_done = (mode_r == GMF_INIT) ? timer_r == 32'(SETTLE_CYCLES - 1)
                                             : timer_r == 32'(STARTUP_CYCLES - 1);
    assign to_init = ext_rst || (mode_r == GMF_NORMAL && cmd[GMF_CMD_RESET])
                     || (mode_r == GMF_SERVICE && cmd[GMF_CMD_EXIT_INIT]); // R2
    assign send_done = mode_r == GMF_SEND && pend_r[3:1] == 3'h0 && !ext_rst;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r <= GMF_INIT; // R2
        end
        else if (to_init)
        begin
            mode_r <= GMF_INIT; // R1 R2
        end
        else
        begin
            case (mode_r)
                GMF_INIT:
                    if (timer_done)
                    begin
                        mode_r <= GMF_SEND; // R3
                    end
                GMF_SEND:
                    if (send_done)
                    begin
                        mode_r <= GMF_NORMAL; // R4
                    end
                GMF_NORMAL:
                    if (cmd[GMF_CMD_SVC])
                    begin
                        mode_r <= GMF_SERVICE;
                    end
                GMF_SERVICE:
                    if (cmd[GMF_CMD_EXIT_NORM])
                    begin
                        mode_r <= GMF_NORMAL; // R9
                    end
                default: mode_r <= GMF_INIT;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_r <= 32'h0;
        end
        else if (to_init || mode_r == GMF_SEND || mode_r == GMF_SERVICE)
        begin
            timer_r <= 32'h0;
        end
        else if (!timer_done)
        begin
            timer_r <= timer_r + 32'h1; // R3 R8
        end
    end
    // start-up flag only follows init; service exit leaves it clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            startup_r <= 1'b0;
        end
        else if (send_done)
        begin
            startup_r <= 1'b1; // R8
        end
        else if (to_init || mode_r != GMF_NORMAL || timer_done)
        begin
            startup_r <= 1'b0; // R8 R9
        end
    end

    // internal sample clock; held in init so channels restart together
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            smp_cnt_r <= 32'h0;
            tick_r <= 1'b0;
        end
        else if (mode_r == GMF_INIT)
        begin
            smp_cnt_r <= 32'h0; // R3
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= smp_cnt_r == 32'(SAMPLE_CYCLES - 1); // R6
            smp_cnt_r <= (smp_cnt_r == 32'(SAMPLE_CYCLES - 1)) ? 32'h0 : smp_cnt_r + 32'h1;
        end
    end
    // latency in microseconds since the latest filtered sample
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            us_cnt_r <= 7'h0;
            lat_r <= 16'h0;
        end
        else if (tick_r)
        begin
            us_cnt_r <= 7'h0;
            lat_r <= 16'h0; // R13
        end
        else if (us_cnt_r == 7'(GMF_US_CYCLES - 1))
        begin
            us_cnt_r <= 7'h0;
            lat_r <= (lat_r == 16'hffff) ? lat_r : lat_r + 16'h1; // R13
        end
        else
        begin
            us_cnt_r <= us_cnt_r + 7'h1;
        end
    end

    // filtering and accumulation
    always_comb
    begin
        filt_nxt[0] = lpf(filt_r[0], rate_x, ctrl_r[GMF_LPF_LSB +: 4]); // R19
        filt_nxt[1] = lpf(filt_r[1], rate_y, ctrl_r[GMF_LPF_LSB +: 4]);
        filt_nxt[2] = lpf(filt_r[2], rate_z, ctrl_r[GMF_LPF_LSB +: 4]);
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int a = 0; a < 3; a++)
            begin
                filt_r[a] <= 24'sh0;
                sum_r[a] <= 48'sh0;
            end
            acc_cnt_r <= 16'h0;
        end
        else if (mode_r == GMF_INIT)
        begin
            for (int a = 0; a < 3; a++)
            begin
                filt_r[a] <= 24'sh0; // R3
                sum_r[a] <= 48'sh0;
            end
            acc_cnt_r <= 16'h0;
        end
        else
        begin
            for (int a = 0; a < 3; a++)
            begin
                if (tick_r)
                begin
                    filt_r[a] <= filt_nxt[a]; // R6 R14
                end
                if (emit[0])
                begin
                    sum_r[a] <= tick_r ? 48'(filt_nxt[a]) : 48'sh0; // R16
                end
                else if (tick_r && acc_cnt_r != 16'hffff)
                begin
                    sum_r[a] <= sum_r[a] + 48'(filt_nxt[a]); // R18 R19
                end
            end
            if (emit[0])
            begin
                acc_cnt_r <= tick_r ? 16'h1 : 16'h0; // R16
            end
            else if (tick_r && acc_cnt_r != 16'hffff)
            begin
                acc_cnt_r <= acc_cnt_r + 16'h1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_r <= 8'h0;
            free_cnt_r <= 8'h0;
        end
        else if (mode_r == GMF_INIT)
        begin
            div_cnt_r <= 8'h0;
            free_cnt_r <= 8'h0;
        end
        else if (tick_r)
        begin
            free_cnt_r <= free_cnt_r + 8'h1;
            div_cnt_r <= (div_cnt_r >= div_eff - 8'h1) ? 8'h0 : div_cnt_r + 8'h1;
        end
    end

    // pending datagrams; a new request wins over its own clear
    assign meas_set = mode_r == GMF_NORMAL && (trig_mode ? trig_fall // R10 R11
                      : tick_r && div_cnt_r >= div_eff - 8'h1); // R6
    always_comb
    begin
        emit = 4'h0;
        if ((mode_r == GMF_SEND || mode_r == GMF_NORMAL) && tx_ready)
        begin
            if (pend_r[1])
            begin
                emit[1] = 1'b1; // R22
            end
            else if (pend_r[2])
            begin
                emit[2] = 1'b1; // R22
            end
            else if (pend_r[3])
            begin
                emit[3] = 1'b1; // R22
            end
            else if (pend_r[0] && mode_r == GMF_NORMAL)
            begin
                emit[0] = 1'b1; // R7
            end
        end
        pend_nxt = pend_r & ~emit;
        pend_nxt[0] = pend_nxt[0] | meas_set; // R11
        if (mode_r == GMF_NORMAL)
        begin
            pend_nxt[3:1] = pend_nxt[3:1] | cmd[GMF_CMD_CONFIG:GMF_CMD_PART]; // R5
        end
        if (mode_r == GMF_INIT && timer_done)
        begin
            pend_nxt = 4'he; // R3 R12
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_r <= 4'h0;
        end
        else if (to_init || mode_r == GMF_SERVICE)
        begin
            pend_r <= 4'h0;
        end
        else
        begin
            pend_r <= pend_nxt;
        end
    end

    // datagram output; status comes from this cycle only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dg_valid_r <= 1'b0;
            dg_kind_r <= GMF_DG_MEAS;
            dg_x_r <= 24'h0;
            dg_y_r <= 24'h0;
            dg_z_r <= 24'h0;
            dg_status_r <= 8'h0;
            dg_count_r <= 8'h0;
            dg_latency_r <= 16'h0;
        end
        else
        begin
            dg_valid_r <= |emit;
            if (emit[0])
            begin
                dg_kind_r <= GMF_DG_MEAS;
                dg_x_r <= fmt(sum_r[0], acc_cnt_r, filt_r[0], unit); // R14 R15 R17 R18
                dg_y_r <= fmt(sum_r[1], acc_cnt_r, filt_r[1], unit);
                dg_z_r <= fmt(sum_r[2], acc_cnt_r, filt_r[2], unit);
                dg_status_r <= {diag_status[GMF_ST_SYS], startup_r, diag_status[5:0]}; // R20 R21
                dg_count_r <= (unit == GMF_UNIT_RATE) ? free_cnt_r : acc_cnt_r[7:0];
                dg_latency_r <= lat_r; // R13
            end
            else if (|emit)
            begin
                dg_kind_r <= emit[1] ? GMF_DG_PART : emit[2] ? GMF_DG_SERIAL : GMF_DG_CONFIG;
                dg_x_r <= emit[1] ? PART_ID : emit[2] ? SERIAL_ID : ctrl_r[23:0];
                dg_y_r <= 24'h0;
                dg_z_r <= 24'h0;
                dg_status_r <= {diag_status[GMF_ST_SYS], startup_r, diag_status[5:0]}; // R21
            end
        end
    end

    sequence s_init_exit;
        mode_r == GMF_SEND && pend_r[3:1] == 3'h0 && !ext_rst;
    endsequence
    sequence s_trig_req;
        trig_fall && trig_mode && mode_r == GMF_NORMAL && !to_init;
    endsequence

    property p_ext_reset;
        @(posedge pclk) disable iff (!presetn) ext_rst |=> mode_r == GMF_INIT;
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("pin reset did not enter init"); // R1
    property p_to_normal;
        @(posedge pclk) disable iff (!presetn) s_init_exit |=> mode_r == GMF_NORMAL ##0 startup_r;
    endproperty
    a_to_normal: assert property (p_to_normal) else $error("init exit without start-up"); // R4 R8
    property p_request;
        @(posedge pclk) disable iff (!presetn)
            mode_r == GMF_NORMAL && cmd[GMF_CMD_SERIAL] && !to_init |=> pend_r[2];
    endproperty
    a_request: assert property (p_request) else $error("special request lost"); // R5
    property p_svc_skip;
        @(posedge pclk) disable iff (!presetn)
            mode_r == GMF_NORMAL && $past(mode_r) == GMF_SERVICE |-> !startup_r;
    endproperty
    a_svc_skip: assert property (p_svc_skip) else $error("start-up flagged after service"); // R9
    property p_trig_pend;
        @(posedge pclk) disable iff (!presetn) s_trig_req |=> pend_r[0];
    endproperty
    a_trig_pend: assert property (p_trig_pend) else $error("trigger edge lost"); // R11
    property p_trig_only;
        @(posedge pclk) disable iff (!presetn)
            $rose(pend_r[0]) && $past(trig_mode) |-> $past(trig_fall);
    endproperty
    a_trig_only: assert property (p_trig_only) else $error("send without trigger edge"); // R10
    property p_order;
        @(posedge pclk) disable iff (!presetn)
            dg_valid_r && dg_kind_r == GMF_DG_SERIAL && mode_r == GMF_SEND |-> !pend_r[1];
    endproperty
    a_order: assert property (p_order) else $error("serial sent before part"); // R22
    property p_svc_silent;
        @(posedge pclk) disable iff (!presetn)
            mode_r == GMF_SERVICE ##1 mode_r == GMF_SERVICE |-> !dg_valid_r;
    endproperty
    a_svc_silent: assert property (p_svc_silent) else $error("datagram sent in service"); // R12
    property p_status6;
        @(posedge pclk) disable iff (!presetn)
            dg_valid_r && dg_kind_r == GMF_DG_MEAS |-> dg_status_r[GMF_ST_START] == $past(startup_r);
    endproperty
    a_status6: assert property (p_status6) else $error("status bit 6 wrong"); // R8 R20
    property p_rate_latest;
        @(posedge pclk) disable iff (!presetn)
            dg_valid_r && dg_kind_r == GMF_DG_MEAS && $past(unit) == GMF_UNIT_RATE
            |-> dg_x_r == $past(filt_r[0]);
    endproperty
    a_rate_latest: assert property (p_rate_latest) else $error("rate not latest sample"); // R14
endmodule
`default_nettype wire

// ===== test/gmf_host.sv
`timescale 1ns/1ps
`default_nettype none
module gmf_host
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic dg_valid,
    input wire logic [1:0] dg_kind,
    input wire logic [23:0] dg_x,
    input wire logic [7:0] dg_status,
    input wire logic [7:0] dg_count,
    output logic tx_ready
);
    logic [41:0] got[$];
    // every datagram is kept whatever its status; the bench checks the status byte of selected measurement datagrams only
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_ready <= 1'b0;
        else
            tx_ready <= slow ? ~tx_ready : 1'b1;
        if (presetn && dg_valid)
            got.push_back({dg_kind, dg_x, dg_status, dg_count});
    end
endmodule
`default_nettype wire

// ===== test/gyro_mode_and_output_formatter_test.sv
`timescale 1ns/1ps
`default_nettype none
module gyro_mode_and_output_formatter_test;
    import gmf_pkg::*;
    // arbitrary identity values
    localparam logic [23:0] PID = 24'h00c3c3;
    localparam logic [23:0] SID = 24'h000777;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, slv, dg_valid, tx_ready;
    logic module_reset_low = 1'b1, sample_trigger_in = 1'b1;
    logic signed [23:0] rx = -24'sd1000;
    logic [7:0] diag = 8'h91, dg_status, dg_count;
    logic [23:0] dg_x, dg_y, dg_z;
    logic [15:0] lat;
    logic [23:0] ids[4] = '{24'h0, PID, SID, 24'h000400};
    logic [23:0] ux[3] = '{24'h0, 24'hfffe00, 24'hfffc18};
    gmf_dg_type dg_kind;
    logic [41:0] d;
    int err_total = 0;
    int checks_done = 0;
    always #5 pclk = ~pclk;
    gmf_formatter #(.SAMPLE_CYCLES(50), .SETTLE_CYCLES(20), .STARTUP_CYCLES(400), .PART_ID(PID), .SERIAL_ID(SID))
    u_dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .module_reset_low(module_reset_low),
        .sample_trigger_in(sample_trigger_in), .rate_x(rx), .rate_y(rx), .rate_z(rx), .diag_status(diag),
        .tx_ready(tx_ready), .dg_valid(dg_valid), .dg_kind(dg_kind), .dg_x(dg_x), .dg_y(dg_y), .dg_z(dg_z),
        .dg_status(dg_status), .dg_count(dg_count), .dg_latency(lat)
    );
    gmf_host u_host
    (
        .pclk(pclk), .presetn(presetn), .slow(slow), .dg_valid(dg_valid), .dg_kind(dg_kind), .dg_x(dg_x),
        .dg_status(dg_status), .dg_count(dg_count), .tx_ready(tx_ready)
    );
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        // no assumed wait count: only the watchdog ends a hung transfer
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, q & m);
    endtask
    task automatic next_dg();
        int k;
        k = 0;
        while (u_host.got.size() == 0 && k < 3000)
        begin
            @(posedge pclk);
            k++;
        end
        if (u_host.got.size() == 0)
        begin
            chk("datagram arrival", 1, 0);
            d = 'x;
        end
        else
            d = u_host.got.pop_front();
    endtask
    task automatic specials(input bit cfg);
        for (int i = 1; i < 4; i++)
        begin
            next_dg();
            chk("special kind", i, d[41:40]);
            if (i < 3 || cfg)
                chk("special data", ids[i], d[39:16]);
        end
        $display("end of special datagram test");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd("ctrl reset", GMF_CTRL_OFS, 32'hffffffff, GMF_CTRL_RST);
        rd("mode after reset", GMF_STAT_OFS, 32'hf, 32'h1);
        rd("unmapped read", 12'h010, 32'hffffffff, 32'h0);
        chk("unmapped slverr", 1, slv);
        specials(1);
        next_dg();
        chk("start-up status", 8'hd1, d[15:8]);
        chk("rate value", 24'hfffc18, d[39:16]);
        for (int k = 0; k < 100; k++)
        begin
            apb(1'b0, GMF_STAT_OFS, 32'h0);
            if (q[8] === 1'b0)
                break;
        end
        u_host.got.delete();
        next_dg();
        chk("status after start-up", 8'h91, d[15:8]);
        diag <= 8'h00;
        u_host.got.delete();
        next_dg();
        chk("status not latched", 8'h00, d[15:8]);
        for (int u = 1; u < 3; u++)
        begin
            apb(1'b1, GMF_CTRL_OFS, 32'h400 | u);
            u_host.got.delete();
            next_dg();
            next_dg();
            chk("unit value", ux[u], d[39:16]);
            chk("unit count", 4, d[7:0]);
            chk("unit y", ux[u], dg_y);
            chk("unit z", ux[u], dg_z);
        end
        $display("end of output unit test");
        apb(1'b1, GMF_CTRL_OFS, 32'h404);
        repeat (10) @(posedge pclk);
        u_host.got.delete();
        repeat (300) @(posedge pclk);
        chk("quiet without trigger", 0, u_host.got.size());
        sample_trigger_in <= 1'b0;
        repeat (20) @(posedge pclk);
        sample_trigger_in <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("one per edge", 1, u_host.got.size());
        next_dg();
        chk("triggered kind", 0, d[41:40]);
        // sample period here is below one microsecond, so latency reads zero
        chk("latency", 0, lat);
        apb(1'b1, GMF_CMD_OFS, 32'h2);
        next_dg();
        chk("requested part", {2'h1, PID}, d[41:16]);
        apb(1'b1, GMF_CMD_OFS, 32'hc);
        next_dg();
        chk("requested serial", {2'h2, SID}, d[41:16]);
        next_dg();
        chk("requested config", {2'h3, 24'h000404}, d[41:16]);
        $display("end of trigger test");
        apb(1'b1, GMF_CMD_OFS, 32'h10);
        rd("service mode", GMF_STAT_OFS, 32'hf, 32'h8);
        apb(1'b1, GMF_CMD_OFS, 32'h20);
        rd("normal without start-up", GMF_STAT_OFS, 32'h10f, 32'h4);
        apb(1'b1, GMF_CMD_OFS, 32'h1);
        slow <= 1'b1;
        rd("init by command", GMF_STAT_OFS, 32'hf, 32'h1);
        specials(0);
        slow <= 1'b0;
        module_reset_low <= 1'b0;
        repeat (5) @(posedge pclk);
        module_reset_low <= 1'b1;
        rd("init by pin", GMF_STAT_OFS, 32'hf, 32'h1);
        specials(0);
        apb(1'b1, GMF_CMD_OFS, 32'h10);
        apb(1'b1, GMF_CMD_OFS, 32'h40);
        rd("init from service", GMF_STAT_OFS, 32'hf, 32'h1);
        complete_run();
    end
    initial
    begin
        repeat (50000) @(posedge pclk);
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
